// ===== sps_cfg.svh
/*
  Offsets, field positions, reset values and state codes of the switch
  status register and of the power-management control view.
  Assumes it is included by bare name, once per compilation unit.
*/
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

// register addresses on the register access port
`define SPS_ADDR_W 12
`define SPS_OFS_PM_VIEW 12'h078
`define SPS_OFS_SWITCH_STATUS 12'h0A0

// power-management control view, both layouts
`define SPS_LAYOUT_BIT 31
`define SPS_L1ET_MSB 15
`define SPS_L1ET_LSB 0
`define SPS_L0ET_MSB 27
`define SPS_L0ET_LSB 16
`define SPS_L1ET_RESET 16'h03E8
`define SPS_L0ET_RESET 12'h6D6
`define SPS_PM_CURRENT_STATE_MSB 5
`define SPS_PM_CURRENT_STATE_RESET 6'h3F

// current-state codes
`define SPS_PM_L0 6'h00
`define SPS_PM_L0S_ENTRY 6'h01
`define SPS_PM_L0S 6'h02
`define SPS_PM_L1PCIPM_FIRST 6'h03
`define SPS_PM_L1PCIPM_LAST 6'h0A
`define SPS_PM_L1COMPLY_FIRST 6'h0B
`define SPS_PM_L1COMPLY_LAST 6'h0D
`define SPS_PM_L1ACCEPT_FIRST 6'h0E
`define SPS_PM_L1ACCEPT_LAST 6'h10
`define SPS_PM_L1REJECT 6'h11
`define SPS_PM_L1TIMED_FIRST 6'h12
`define SPS_PM_L1TIMED_LAST 6'h16
`define SPS_PM_L1ENTRY_FIRST 6'h17
`define SPS_PM_L1ENTRY_LAST 6'h19
`define SPS_PM_L1 6'h1A
`define SPS_PM_L23_ENTRY_FIRST 6'h1D
`define SPS_PM_L23_READY 6'h23

// switch status fields
`define SPS_STRAP_W 12
`define SPS_MODE_MSB 3
`define SPS_MODE_LSB 0
`define SPS_STRAP_MSB 11
`define SPS_MARKER_MSB 16
`define SPS_MARKER_LSB 13
`define SPS_MARKER_RESET 4'h0
`define SPS_IRQ_MSB 23
`define SPS_IRQ_LSB 20
`define SPS_STRAP_RESET 12'h000

`endif

// ===== sps_pkg.sv
/*
  Types shared by the switch status block: switch-mode codes and the
  strap capture states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sps_pkg;

  // switch-mode strap codes; anything else is reserved
  typedef enum logic [3:0] {
    SPS_MODE_RSVD0 = 4'h0,
    SPS_MODE_RSVD1 = 4'h1,
    SPS_MODE_NTB = 4'h2,
    SPS_MODE_NTB_INIT = 4'h3,
    SPS_MODE_FAILOVER = 4'h4,
    SPS_MODE_FAILOVER_INIT = 4'h5
  } sps_mode_e;

  // strap capture: waiting for reset release, then holding
  typedef enum logic [1:0] {
    SPS_CAP_WAIT = 2'b01,
    SPS_CAP_HELD = 2'b10
  } sps_cap_e;

endpackage

// ===== sps_strap_capture.sv
/*
  Strap pin synchroniser and one-shot capture at fundamental reset release.
  Assumes RESET_N is held low for at least two clock edges so the
  synchroniser has settled before the capture edge.
*/
`include "sps_cfg.svh"

module sps_strap_capture
  import sps_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`SPS_STRAP_W-1:0] strap_in,
  output logic [`SPS_STRAP_W-1:0] strap_q,
  output logic captured
);

  logic [`SPS_STRAP_W-1:0] sync_a;
  logic [`SPS_STRAP_W-1:0] sync_b;
  sps_cap_e cap_state;

  ////////////////////////////////////////////////////////////////////////////
  // two flops per strap; not reset, so they are settled when reset lifts
  for (genvar i = 0; i < `SPS_STRAP_W; i++) begin : g_sync
    always_ff @(posedge clk) begin
      sync_a[i] <= strap_in[i];
      sync_b[i] <= sync_a[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture on the first edge after release, then hold until next reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cap_state <= SPS_CAP_WAIT;
      strap_q <= `SPS_STRAP_RESET;
    end else begin
      case (cap_state)
        SPS_CAP_WAIT: begin
          strap_q <= sync_b;
          cap_state <= SPS_CAP_HELD;
        end
        SPS_CAP_HELD: begin
          cap_state <= SPS_CAP_HELD;
        end
        default: begin
          cap_state <= SPS_CAP_WAIT;
        end
      endcase
    end
  end

  assign captured = (cap_state == SPS_CAP_HELD);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_release;
    !reset_n ##1 reset_n;
  endsequence

  property p_strap_capture;
    @(posedge clk) s_release |=> (strap_q == $past(sync_b)) && captured;
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("strap value not captured at reset release");

  property p_strap_hold;
    @(posedge clk) disable iff (!reset_n)
      captured |=> $stable(strap_q) && captured;
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("captured strap value changed before fundamental reset");

endmodule

// ===== sps_regs.sv
/*
  Switch status register and power-management control view, reached
  through a simple register access port fed by configuration reads or
  the SMBus slave.
  Assumes the port requests come from logic on CLK, one request a cycle,
  read and write never in the same cycle; strap pins are asynchronous.
*/
`include "sps_cfg.svh"
// How it works
// - bit 31 of the control view picks state-readout layout (1) or timer layout (0).
// - six-bit current-state field shows live PM state machine, 0x3F after reset.
// - state codes: L0 is 0, L0s entry 1, L0s 2.
// - eight L1 PCI-PM negotiation substates use codes 3 to 10.
// - L1 comply 11-13, L1 accept 14-16, L1 reject 17.
// - timed L1 18-22, L1 entry 23-25, settled L1 26.
// - L2/L3-ready entry from 29 upward; 35 is ready and also link down.
// - switch-mode field loads from the mode straps when leaving reset.
// - modes 2 to 5 are defined; 0, 1 and 6 upward are reserved.
// - status bits 4 and 5 hold downstream and upstream common-clock straps.
// - status bit 6 holds the master SMBus slow-mode strap.
// - status bits 7, 8, 9 hold lane-reversal straps of ports A, B, C.
// - status bit 10 holds the reference-clock mode strap.
// - status bit 11 holds the reset-halt strap.
// - four-bit marker is read/write, resets to zero, survives hot reset.
// - status bit 20 shows aggregated legacy interrupt A, one when asserted.
// - status bits 21 to 23 show aggregated legacy interrupts B, C, D.
module sps_regs
  import sps_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic HOT_RESET_N,
  input wire logic [3:0] SWITCH_OPERATING_STRAP,
  input wire logic COMMON_CLOCK_DOWNSTREAM,
  input wire logic COMMON_CLOCK_UPSTREAM,
  input wire logic MASTER_SMBUS_SLOW,
  input wire logic PORT_A_LANE_REVERSE,
  input wire logic PORT_B_LANE_REVERSE,
  input wire logic PORT_C_LANE_REVERSE,
  input wire logic REFERENCE_CLOCK_SELECT,
  input wire logic RESET_HALT_STRAP,
  input wire logic [5:0] PM_STATE_IN,
  input wire logic [3:0] LEGACY_IRQ_STATE,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [`SPS_ADDR_W-1:0] REG_ADDR,
  input wire logic [3:0] REG_BE,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  output logic REG_RVALID,
  output logic STRAPS_CAPTURED,
  output sps_pkg::sps_mode_e SWITCH_MODE,
  output logic SWITCH_MODE_VALID,
  output logic LAYOUT_SELECT,
  output logic [15:0] L1_ENTRY_TIMER,
  output logic [11:0] L0S_ENTRY_TIMER,
  output logic PM_IN_L0S,
  output logic PM_IN_L1,
  output logic PM_IN_L23
);

  import sps_pkg::*;

  logic [`SPS_STRAP_W-1:0] strap_pins;
  logic [`SPS_STRAP_W-1:0] strap_q;
  logic straps_captured;
  logic [5:0] pm_state_q;
  logic [3:0] irq_q;
  logic [3:0] marker;
  logic layout_sel;
  logic [15:0] l1_timer;
  logic [11:0] l0s_timer;
  logic [31:0] be_mask;
  logic [31:0] wr_bits;
  logic sel_pm_view;
  logic sel_status;
  logic [31:0] pm_view_word;
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  logic next_in_l0s;
  logic next_in_l1;
  logic next_in_l23;
  logic next_mode_valid;
  logic in_l0s;
  logic in_l1;
  logic in_l23;
  logic mode_valid;

  ////////////////////////////////////////////////////////////////////////////
  // strap pins gathered in status-bit order, synchronised and captured once
  assign strap_pins = {RESET_HALT_STRAP, REFERENCE_CLOCK_SELECT, PORT_C_LANE_REVERSE,
                       PORT_B_LANE_REVERSE, PORT_A_LANE_REVERSE, MASTER_SMBUS_SLOW,
                       COMMON_CLOCK_UPSTREAM, COMMON_CLOCK_DOWNSTREAM,
                       SWITCH_OPERATING_STRAP};

  sps_strap_capture u_capture (
    .clk(CLK),
    .reset_n(RESET_N),
    .strap_in(strap_pins),
    .strap_q(strap_q),
    .captured(straps_captured)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode and byte-lane write mask
  always_comb begin
    if (REG_ADDR == `SPS_OFS_PM_VIEW) begin
      sel_pm_view = 1'b1;
      sel_status = 1'b0;
    end else if (REG_ADDR == `SPS_OFS_SWITCH_STATUS) begin
      sel_pm_view = 1'b0;
      sel_status = 1'b1;
    end else begin
      sel_pm_view = 1'b0;
      sel_status = 1'b0;
    end
  end

  assign be_mask = {{8{REG_BE[3]}}, {8{REG_BE[2]}}, {8{REG_BE[1]}}, {8{REG_BE[0]}}};
  assign wr_bits = REG_WDATA & be_mask;

  ////////////////////////////////////////////////////////////////////////////
  // live PM state; no synchroniser since the link state machine shares CLK
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pm_state_q <= `SPS_PM_CURRENT_STATE_RESET;
    end else begin
      pm_state_q <= PM_STATE_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // aggregated legacy interrupt levels, registered for a clean read word
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      irq_q <= 4'h0;
    end else begin
      irq_q <= LEGACY_IRQ_STATE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // marker: only fundamental reset clears it, so software state survives hot reset
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      marker <= `SPS_MARKER_RESET;
    end else if (REG_WR && sel_status) begin
      marker <= (marker & ~be_mask[`SPS_MARKER_MSB:`SPS_MARKER_LSB]) |
                wr_bits[`SPS_MARKER_MSB:`SPS_MARKER_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // layout select bit; an ordinary field, so hot reset clears it too
  always_ff @(posedge CLK) begin
    if (!RESET_N || !HOT_RESET_N) begin
      layout_sel <= 1'b0;
    end else if (REG_WR && sel_pm_view && REG_BE[3]) begin
      layout_sel <= REG_WDATA[`SPS_LAYOUT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry timers exist only in the timer layout; the readout layout shows
  // those bits as read-only, so writes there leave the timers alone
  always_ff @(posedge CLK) begin
    if (!RESET_N || !HOT_RESET_N) begin
      l1_timer <= `SPS_L1ET_RESET;
      l0s_timer <= `SPS_L0ET_RESET;
    end else if (REG_WR && sel_pm_view && !layout_sel) begin
      l1_timer <= (l1_timer & ~be_mask[`SPS_L1ET_MSB:`SPS_L1ET_LSB]) |
                  wr_bits[`SPS_L1ET_MSB:`SPS_L1ET_LSB];
      l0s_timer <= (l0s_timer & ~be_mask[`SPS_L0ET_MSB:`SPS_L0ET_LSB]) |
                   wr_bits[`SPS_L0ET_MSB:`SPS_L0ET_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the two views of the control register; reserved bits are hard zeros
  always_comb begin
    pm_view_word = 32'h0000_0000;
    pm_view_word[`SPS_LAYOUT_BIT] = layout_sel;
    if (layout_sel) begin
      pm_view_word[`SPS_PM_CURRENT_STATE_MSB:0] = pm_state_q;
    end else begin
      pm_view_word[`SPS_L1ET_MSB:`SPS_L1ET_LSB] = l1_timer;
      pm_view_word[`SPS_L0ET_MSB:`SPS_L0ET_LSB] = l0s_timer;
    end
  end

  // status word: captured straps low, marker, interrupt levels, zeros elsewhere
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`SPS_STRAP_MSB:0] = strap_q;
    status_word[`SPS_MARKER_MSB:`SPS_MARKER_LSB] = marker;
    status_word[`SPS_IRQ_MSB:`SPS_IRQ_LSB] = irq_q;
  end

  // unmapped addresses read as zero rather than stalling the requester
  always_comb begin
    if (sel_pm_view) begin
      next_rdata = pm_view_word;
    end else if (sel_status) begin
      next_rdata = status_word;
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data held in a flop until the next read
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // classify the state code for power control; 35 counts as L2/L3 even
  // though the same code also means link down, which cannot be told apart
  always_comb begin
    next_in_l0s = (pm_state_q == `SPS_PM_L0S_ENTRY) || (pm_state_q == `SPS_PM_L0S);
    next_in_l1 = (pm_state_q >= `SPS_PM_L1PCIPM_FIRST) &&
                 (pm_state_q <= `SPS_PM_L1);
    next_in_l23 = (pm_state_q >= `SPS_PM_L23_ENTRY_FIRST) &&
                  (pm_state_q <= `SPS_PM_L23_READY);
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      in_l0s <= 1'b0;
      in_l1 <= 1'b0;
      in_l23 <= 1'b0;
    end else begin
      in_l0s <= next_in_l0s;
      in_l1 <= next_in_l1;
      in_l23 <= next_in_l23;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch-mode validity from the captured code
  always_comb begin
    next_mode_valid = (strap_q[`SPS_MODE_MSB:`SPS_MODE_LSB] >= SPS_MODE_NTB) &&
                      (strap_q[`SPS_MODE_MSB:`SPS_MODE_LSB] <= SPS_MODE_FAILOVER_INIT);
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      mode_valid <= 1'b0;
    end else begin
      mode_valid <= next_mode_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the rest of the switch
  assign STRAPS_CAPTURED = straps_captured;
  assign SWITCH_MODE = sps_mode_e'(strap_q[`SPS_MODE_MSB:`SPS_MODE_LSB]);
  assign SWITCH_MODE_VALID = mode_valid;
  assign LAYOUT_SELECT = layout_sel;
  assign L1_ENTRY_TIMER = l1_timer;
  assign L0S_ENTRY_TIMER = l0s_timer;
  assign PM_IN_L0S = in_l0s;
  assign PM_IN_L1 = in_l1;
  assign PM_IN_L23 = in_l23;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_read_view;
    REG_RD && (REG_ADDR == `SPS_OFS_PM_VIEW);
  endsequence

  sequence s_read_status;
    REG_RD && (REG_ADDR == `SPS_OFS_SWITCH_STATUS);
  endsequence

  property p_layout_timer;
    @(posedge CLK) disable iff (!RESET_N)
      s_read_view ##0 !layout_sel |=> !REG_RDATA[31] && (REG_RDATA[30:28] == 3'h0) &&
        (REG_RDATA[27:16] == $past(l0s_timer)) && (REG_RDATA[15:0] == $past(l1_timer));
  endproperty
  a_layout_timer: assert property (p_layout_timer)
    else $error("timer layout read wrong");

  property p_layout_state;
    @(posedge CLK) disable iff (!RESET_N)
      s_read_view ##0 layout_sel |=> REG_RDATA[31] && (REG_RDATA[30:6] == 25'h0) &&
        (REG_RDATA[5:0] == $past(PM_STATE_IN, 2));
  endproperty
  a_layout_state: assert property (p_layout_state)
    else $error("state readout layout does not show live state");

  property p_pm_default;
    @(posedge CLK) !RESET_N |=> (pm_state_q == 6'h3F);
  endproperty
  a_pm_default: assert property (p_pm_default)
    else $error("current state not 0x3F after reset");

  property p_class_l1;
    @(posedge CLK) disable iff (!RESET_N)
      $past(RESET_N) && (pm_state_q inside {[6'd3:6'd26]}) |=> PM_IN_L1 && !PM_IN_L23;
  endproperty
  a_class_l1: assert property (p_class_l1)
    else $error("L1 family code not classified as L1");

  property p_class_low;
    @(posedge CLK) disable iff (!RESET_N)
      (pm_state_q <= 6'd2) |=> !PM_IN_L1 && !PM_IN_L23 && (PM_IN_L0S == ($past(pm_state_q) != 6'd0));
  endproperty
  a_class_low: assert property (p_class_low)
    else $error("L0 or L0s code misclassified");

  property p_class_l23;
    @(posedge CLK) disable iff (!RESET_N)
      (pm_state_q inside {[6'd29:6'd35]}) |=> PM_IN_L23 && !PM_IN_L1;
  endproperty
  a_class_l23: assert property (p_class_l23)
    else $error("L2/L3 code not classified");

  property p_status_read;
    @(posedge CLK) disable iff (!RESET_N)
      s_read_status |=> (REG_RDATA[23:20] == $past(irq_q)) && (REG_RDATA[11:0] == $past(strap_q))
        && (REG_RDATA[12] == 1'b0) && (REG_RDATA[19:17] == 3'h0) && (REG_RDATA[31:24] == 8'h00);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status word fields wrong");

  property p_marker_write;
    @(posedge CLK) disable iff (!RESET_N)
      REG_WR && (REG_ADDR == `SPS_OFS_SWITCH_STATUS) && (REG_BE == 4'hF)
        |=> (marker == $past(REG_WDATA[16:13]));
  endproperty
  a_marker_write: assert property (p_marker_write)
    else $error("marker write not stored");

  property p_marker_hot;
    @(posedge CLK) disable iff (!RESET_N)
      !HOT_RESET_N && !REG_WR |=> $stable(marker);
  endproperty
  a_marker_hot: assert property (p_marker_hot)
    else $error("marker changed by hot reset");

  property p_mode_valid;
    @(posedge CLK) disable iff (!RESET_N)
      STRAPS_CAPTURED ##1 STRAPS_CAPTURED |-> (SWITCH_MODE_VALID ==
        ((SWITCH_MODE >= 4'h2) && (SWITCH_MODE <= 4'h5)));
  endproperty
  a_mode_valid: assert property (p_mode_valid)
    else $error("switch mode validity wrong");

  property p_hot_layout;
    @(posedge CLK) disable iff (!RESET_N)
      !HOT_RESET_N |=> !LAYOUT_SELECT && (L1_ENTRY_TIMER == 16'h03E8) &&
        (L0S_ENTRY_TIMER == 12'h6D6);
  endproperty
  a_hot_layout: assert property (p_hot_layout)
    else $error("hot reset did not restore timer layout");

endmodule

// ===== sps_host_model.sv
/*
  Register master model: the configuration or SMBus side that issues
  read and write strobes on the register access port, each held until the next task or idle call.
  Assumes its tasks are entered just after a rising CLK edge.
*/
`include "sps_cfg.svh"

module sps_host_model (
  input wire logic CLK,
  output logic REG_WR,
  output logic REG_RD,
  output logic [`SPS_ADDR_W-1:0] REG_ADDR,
  output logic [3:0] REG_BE,
  output logic [31:0] REG_WDATA
);
  timeunit 1ns;
  timeprecision 1ns;

  //////////////////////////////////////////////////////////////////////////
  // idle values at time zero
  initial begin
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = '0;
    REG_BE = 4'h0;
    REG_WDATA = 32'h0000_0000;
  end

  // strobe stays up after the task so back-to-back requests need no gap
  task automatic wr(input logic [`SPS_ADDR_W-1:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    REG_RD = 1'b0;
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_BE = be;
    REG_WDATA = d;
    @(posedge CLK);
    #10;
  endtask

  // state view is read here rather than by configuration requests
  task automatic rd(input logic [`SPS_ADDR_W-1:0] a);
    REG_WR = 1'b0;
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(posedge CLK);
    #10;
  endtask

  // released lines flip so a stale address or data is never reused
  task automatic idle();
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = ~REG_ADDR;
    REG_WDATA = ~REG_WDATA;
  endtask
endmodule

// ===== sps_regs_tb.sv
/*
  Self-checking bench for the switch status and power-management view.
  Assumes the register master model and a 10 MHz clock; reads are
  checked by a watcher against a queue of expected words.
*/
`include "sps_cfg.svh"

module sps_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sps_pkg::*;

  logic CLK, RESET_N, HOT_RESET_N, REG_RVALID, STRAPS_CAPTURED, SWITCH_MODE_VALID;
  logic LAYOUT_SELECT, PM_IN_L0S, PM_IN_L1, PM_IN_L23;
  logic [11:0] sp, cap, t0, L0S_ENTRY_TIMER;
  logic [5:0] PM_STATE_IN;
  logic [3:0] LEGACY_IRQ_STATE;
  logic [15:0] t1, L1_ENTRY_TIMER;
  logic [31:0] REG_RDATA, rnd;
  sps_mode_e SWITCH_MODE;
  wire logic REG_WR, REG_RD;
  wire logic [`SPS_ADDR_W-1:0] REG_ADDR;
  wire logic [3:0] REG_BE;
  wire logic [31:0] REG_WDATA;
  logic [31:0] expq[$];
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 32'h4839DFF3;

  //////////////////////////////////////////////////////////////////////////
  sps_host_model host (.CLK(CLK), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_BE(REG_BE), .REG_WDATA(REG_WDATA));

  sps_regs dut (.CLK(CLK), .RESET_N(RESET_N), .HOT_RESET_N(HOT_RESET_N),
    .SWITCH_OPERATING_STRAP(sp[3:0]), .COMMON_CLOCK_DOWNSTREAM(sp[4]),
    .COMMON_CLOCK_UPSTREAM(sp[5]), .MASTER_SMBUS_SLOW(sp[6]),
    .PORT_A_LANE_REVERSE(sp[7]), .PORT_B_LANE_REVERSE(sp[8]),
    .PORT_C_LANE_REVERSE(sp[9]), .REFERENCE_CLOCK_SELECT(sp[10]),
    .RESET_HALT_STRAP(sp[11]), .PM_STATE_IN(PM_STATE_IN),
    .LEGACY_IRQ_STATE(LEGACY_IRQ_STATE), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_BE(REG_BE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .STRAPS_CAPTURED(STRAPS_CAPTURED), .SWITCH_MODE(SWITCH_MODE),
    .SWITCH_MODE_VALID(SWITCH_MODE_VALID), .LAYOUT_SELECT(LAYOUT_SELECT),
    .L1_ENTRY_TIMER(L1_ENTRY_TIMER), .L0S_ENTRY_TIMER(L0S_ENTRY_TIMER),
    .PM_IN_L0S(PM_IN_L0S), .PM_IN_L1(PM_IN_L1), .PM_IN_L23(PM_IN_L23));

  //////////////////////////////////////////////////////////////////////////
  // clock, 100 ns period
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  task automatic finish_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #10;
  endtask

  task automatic rd(input logic [`SPS_ADDR_W-1:0] a, input logic [31:0] e);
    expq.push_back(e);
    host.rd(a);
  endtask

  // status word as the captured straps, marker and interrupt levels make it
  function automatic logic [31:0] stat(input logic [3:0] m, input logic [3:0] q);
    return {8'h00, q, 3'b000, m, 1'b0, cap};
  endfunction

  // fundamental reset with new strap levels held across the release
  task automatic do_reset(input logic [11:0] s);
    host.idle();
    RESET_N = 1'b0;
    sp = s;
    cyc(20);
    RESET_N = 1'b1;
    cap = s;
    cyc(2);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // read watcher: each valid pulse retires the oldest expected word
  always @(negedge CLK) begin
    if (REG_RVALID === 1'b1) begin
      if (expq.size() == 0) begin
        chk(REG_RDATA, 32'hFFFF_FFFF);
      end else begin
        chk(REG_RDATA, expq.pop_front());
      end
    end
  end

  // guard against a hung run
  initial begin
    repeat (100000) @(posedge CLK);
    error_cnt++;
    finish_test();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    RESET_N = 1'b0;
    HOT_RESET_N = 1'b1;
    sp = 12'h000;
    cap = 12'h000;
    PM_STATE_IN = 6'h3F;
    LEGACY_IRQ_STATE = 4'h0;
    @(posedge CLK);
    #10;
    // every mode code through its own fundamental reset
    for (int i = 0; i < 16; i++) begin
      rnd = $random(seed);
      do_reset({rnd[11:4], i[3:0]});
      chk(STRAPS_CAPTURED, 32'h1);
      chk(SWITCH_MODE, i);
      chk(SWITCH_MODE_VALID, (i >= 2 && i <= 5));
      rd(`SPS_OFS_SWITCH_STATUS, stat(4'h0, 4'h0));
      rd(`SPS_OFS_PM_VIEW, 32'h06D6_03E8);
    end
    // strap pins move after capture; status must not follow
    host.idle();
    rnd = $random(seed);
    sp = rnd[11:0];
    LEGACY_IRQ_STATE = rnd[15:12];
    cyc(3);
    rd(`SPS_OFS_SWITCH_STATUS, stat(4'h0, rnd[15:12]));
    // marker with all lanes, then with lane 1 off; reserved bits stay zero
    host.wr(`SPS_OFS_SWITCH_STATUS, 4'hF, 32'hFFFF_FFFF);
    rd(`SPS_OFS_SWITCH_STATUS, stat(4'hF, rnd[15:12]));
    host.wr(`SPS_OFS_SWITCH_STATUS, 4'hD, 32'h0000_0000);
    rd(`SPS_OFS_SWITCH_STATUS, stat(4'h7, rnd[15:12]));
    host.wr(12'h0A4, 4'hF, 32'hFFFF_FFFF);
    rd(12'h0A4, 32'h0000_0000);
    // timer layout write and readback
    rnd = $random(seed);
    t1 = rnd[15:0];
    t0 = rnd[27:16];
    host.wr(`SPS_OFS_PM_VIEW, 4'hF, {4'h0, t0, t1});
    rd(`SPS_OFS_PM_VIEW, {4'h0, t0, t1});
    host.idle();
    chk({L0S_ENTRY_TIMER, L1_ENTRY_TIMER}, {4'h0, t0, t1});
    // top lane alone flips to the state layout; it also carries timer bits 27:24
    host.wr(`SPS_OFS_PM_VIEW, 4'h8, {4'h8, t0, t1});
    rd(`SPS_OFS_PM_VIEW, 32'h8000_003F);
    host.wr(`SPS_OFS_PM_VIEW, 4'hF, 32'h8000_0000);
    host.idle();
    chk(LAYOUT_SELECT, 32'h1);
    // every listed state code shows live
    for (int c = 0; c < 36; c++) begin
      PM_STATE_IN = c[5:0];
      cyc(2);
      rd(`SPS_OFS_PM_VIEW, {26'h200_0000, c[5:0]});
      host.idle();
      if (c == 0) chk({PM_IN_L0S, PM_IN_L1, PM_IN_L23}, 32'h0);
      if (c == 2) chk({PM_IN_L0S, PM_IN_L1, PM_IN_L23}, 32'h4);
      if (c == 26) chk({PM_IN_L0S, PM_IN_L1, PM_IN_L23}, 32'h2);
      if (c == 35) chk({PM_IN_L0S, PM_IN_L1, PM_IN_L23}, 32'h1);
    end
    // timers were locked while the state layout was shown
    host.wr(`SPS_OFS_PM_VIEW, 4'h8, 32'h0000_0000);
    rd(`SPS_OFS_PM_VIEW, {4'h0, t0, t1});
    // hot reset clears the view but keeps marker and straps
    host.wr(`SPS_OFS_PM_VIEW, 4'hF, 32'h8000_0000);
    host.idle();
    HOT_RESET_N = 1'b0;
    cyc(3);
    HOT_RESET_N = 1'b1;
    cyc(1);
    chk(LAYOUT_SELECT, 32'h0);
    rd(`SPS_OFS_PM_VIEW, 32'h06D6_03E8);
    rd(`SPS_OFS_SWITCH_STATUS, stat(4'h7, LEGACY_IRQ_STATE));
    // fundamental reset clears the marker and recaptures
    rnd = $random(seed);
    do_reset(rnd[11:0]);
    rd(`SPS_OFS_SWITCH_STATUS, stat(4'h0, LEGACY_IRQ_STATE));
    host.idle();
    for (int k = 0; k < 10 && expq.size() > 0; k++) cyc(1);
    if (expq.size() > 0) error_cnt++;
    finish_test();
  end
endmodule
